//--- design/flash_status_pkg.sv
package flash_status_pkg;
   // register offsets of the controller's own apb block
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ADDR = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_RDDATA = 8'h18;
   // ctrl command codes, written to ctrl bits [2:0]
   localparam logic [2:0] CMD_NONE = 3'h0;
   localparam logic [2:0] CMD_PROGRAM = 3'h1;
   localparam logic [2:0] CMD_SECTOR_ERASE = 3'h2;
   localparam logic [2:0] CMD_ADD_SECTOR = 3'h3;
   localparam logic [2:0] CMD_CHIP_ERASE = 3'h4;
   localparam logic [2:0] CMD_RESET = 3'h5;
   localparam logic [2:0] CMD_READ = 3'h6;
   localparam logic [2:0] CMD_SUSPEND = 3'h7;
   // status bit positions in flash read data
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int FAIL_BIT = 5;
   localparam int WINDOW_BIT = 3;
   localparam int SECT_TOGGLE_BIT = 2;
   // sticky event bits
   localparam int EV_DONE = 0;
   localparam int EV_FAIL = 1;
   localparam int EV_WINDOW_SHUT = 2;
   localparam int EV_ADD_LATE = 3;
   localparam int EV_W = 4;
   // bus cycle timing
   localparam int CLK_NS = 5;
   localparam int WE_PULSE_NS = 40;
   localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int READ_ACC_NS = 80;
   localparam int READ_ACC_CYC = (READ_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int ERASE_WINDOW_US = 50;
   // bus cycle kinds for the pin engine
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
endpackage

//--- design/flash_bus_if.sv
interface flash_bus_if;
   logic req;
   logic [1:0] op;
   logic [19:0] addr;
   logic [15:0] wdata;
   logic done;
   logic [15:0] rdata;
   modport master (output req, output op, output addr, output wdata, input done, input rdata);
   modport engine (input req, input op, input addr, input wdata, output done, output rdata);
endinterface

//--- design/flash_cycle_engine.sv
module flash_cycle_engine
#(
   parameter int PULSE_CYC = flash_status_pkg::WE_PULSE_CYC,
   parameter int ACC_CYC = flash_status_pkg::READ_ACC_CYC
)
(
   // clocking
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // request side
   flash_bus_if.engine bus,
   // flash pins
   output logic [19:0] fl_addr,
   output logic [15:0] fl_dq_out,
   output logic fl_dq_oe_n,
   input wire logic [15:0] fl_dq_in,
   output logic fl_ce_n,
   output logic fl_oe_n,
   output logic fl_we_n
);
   initial
   begin
      if (PULSE_CYC < 1 || ACC_CYC < 1 || PULSE_CYC > 255 || ACC_CYC > 255)
         $error("cycle counts out of range");
   end

   typedef enum logic [2:0] {E_IDLE = 3'b001, E_ACT = 3'b010, E_GAP = 3'b100} est_t;
   est_t st_q, st_d;
   logic [7:0] cnt_q, cnt_d;
   logic wr_q, wr_d;
   logic [19:0] addr_q, addr_d;
   logic [15:0] wd_q, wd_d, rd_q, rd_d;
   logic done_d, done_q;

   // one strobe per request: setup and strobe merged, one idle gap after
   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      wr_d = wr_q;
      addr_d = addr_q;
      wd_d = wd_q;
      rd_d = rd_q;
      done_d = 1'b0;
      case (st_q)
         E_IDLE:
         begin
            if (bus.req)
            begin
               wr_d = (bus.op == flash_status_pkg::OP_WRITE);
               addr_d = bus.addr;
               wd_d = bus.wdata;
               cnt_d = 8'h00;
               st_d = E_ACT;
            end
         end
         E_ACT:
         begin
            cnt_d = cnt_q + 8'h01;
            if (cnt_q == (wr_q ? 8'(PULSE_CYC - 1) : 8'(ACC_CYC - 1)))
            begin
               if (!wr_q)
                  rd_d = fl_dq_in;
               done_d = 1'b1;
               st_d = E_GAP;
            end
         end
         E_GAP:
            st_d = E_IDLE;
         default:
            st_d = E_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= E_IDLE;
         cnt_q <= 8'h00;
         wr_q <= 1'b0;
         addr_q <= 20'h00000;
         wd_q <= 16'h0000;
         rd_q <= 16'h0000;
         done_q <= 1'b0;
      end
      else if (clk_en)
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         wr_q <= wr_d;
         addr_q <= addr_d;
         wd_q <= wd_d;
         rd_q <= rd_d;
         done_q <= done_d;
      end
   end

   // address and data pins come straight from flops, strobes are decoded from the state; data bus released except during writes
   assign fl_addr = addr_q;
   assign fl_dq_out = wd_q;
   assign fl_dq_oe_n = !(st_q == E_ACT && wr_q);
   assign fl_ce_n = (st_q != E_ACT);
   assign fl_oe_n = !(st_q == E_ACT && !wr_q);
   assign fl_we_n = !(st_q == E_ACT && wr_q);
   assign bus.done = done_q;
   assign bus.rdata = rd_q;
endmodule

//--- design/flash_status_ctrl.sv
// How it works
// - after any failure the controller writes the reset command so the device reads array again.
// - the controller never skips the window check, so no 50 us spacing is assumed.
// - acceptance is confirmed by toggle reads, then the window flag is checked before and after adds.
// - status reads use the address of the operation in progress.
//
// Design decisions made here: the APB slave port and the register offsets.
module flash_status_ctrl
(
   // clocking
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt
   output logic irq,
   // flash pins
   output logic [19:0] fl_addr,
   output logic [15:0] fl_dq_out,
   output logic fl_dq_oe_n,
   input wire logic [15:0] fl_dq_in,
   output logic fl_ce_n,
   output logic fl_oe_n,
   output logic fl_we_n,
   input wire logic ready_busy_out
);
   typedef enum logic [9:0] {
      S_IDLE = 10'b0000000001,
      S_CMD = 10'b0000000010,
      S_POLL1 = 10'b0000000100,
      S_POLL2 = 10'b0000001000,
      S_RECHECK = 10'b0000010000,
      S_WIN = 10'b0000100000,
      S_RESET = 10'b0001000000,
      S_READ = 10'b0010000000,
      S_WINPOST = 10'b0100000000,
      S_DONE = 10'b1000000000
   } st_t;

   flash_bus_if fb ();

   flash_cycle_engine u_eng
   (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .bus(fb.engine),
      .fl_addr(fl_addr),
      .fl_dq_out(fl_dq_out),
      .fl_dq_oe_n(fl_dq_oe_n),
      .fl_dq_in(fl_dq_in),
      .fl_ce_n(fl_ce_n),
      .fl_oe_n(fl_oe_n),
      .fl_we_n(fl_we_n)
   );

   st_t st_q, st_d;
   logic [2:0] cmd_q, cmd_d;
   logic [19:0] addr_q, addr_d;
   logic [15:0] data_q, data_d;
   logic [15:0] rdd_q, rdd_d;
   logic [15:0] prev_q, prev_d;
   logic [2:0] idx_q, idx_d;
   logic [3:0] seq_len;
   logic window_open_q, window_open_d;
   logic erase_run_q, erase_run_d;
   logic suspended_q, suspended_d;
   logic failed_q, failed_d;
   logic refused_q, refused_d;
   localparam int EV_W_L = flash_status_pkg::EV_W;
   logic [EV_W_L-1:0] ist_q, ist_d, imask_q, imask_d, ev;
   logic req_d, req_q;
   logic [1:0] op_d, op_q;
   logic [19:0] baddr_d, baddr_q;
   logic [15:0] bwd_d, bwd_q;
   logic go;
   logic [15:0] rd;
   logic toggled;

   // apb: always zero wait, every word address decodes or errors
   wire wr_acc = psel && penable && pwrite;
   wire rd_sel = psel && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(paddr == flash_status_pkg::OFS_CTRL ||
      paddr == flash_status_pkg::OFS_ADDR || paddr == flash_status_pkg::OFS_DATA ||
      paddr == flash_status_pkg::OFS_STATUS || paddr == flash_status_pkg::OFS_IRQ_STAT ||
      paddr == flash_status_pkg::OFS_IRQ_MASK || paddr == flash_status_pkg::OFS_RDDATA);
   assign go = wr_acc && paddr == flash_status_pkg::OFS_CTRL;

   always_comb
   begin
      prdata = 32'h00000000;
      if (rd_sel)
      begin
         case (paddr)
            flash_status_pkg::OFS_CTRL: prdata = {29'h0, cmd_q};
            flash_status_pkg::OFS_ADDR: prdata = {12'h000, addr_q};
            flash_status_pkg::OFS_DATA: prdata = {16'h0000, data_q};
            flash_status_pkg::OFS_STATUS: prdata = {24'h0, refused_q, !ready_busy_out,
               suspended_q, erase_run_q, window_open_q, failed_q, 1'b0, st_q != S_IDLE};
            flash_status_pkg::OFS_IRQ_STAT: prdata = {28'h0, ist_q};
            flash_status_pkg::OFS_IRQ_MASK: prdata = {28'h0, imask_q};
            flash_status_pkg::OFS_RDDATA: prdata = {16'h0000, rdd_q};
            default: prdata = 32'h00000000;
         endcase
      end
   end

   assign fb.req = req_q;
   assign fb.op = op_q;
   assign fb.addr = baddr_q;
   assign fb.wdata = bwd_q;
   assign rd = fb.rdata;
   assign toggled = rd[flash_status_pkg::TOGGLE_BIT] != prev_q[flash_status_pkg::TOGGLE_BIT];

   // unlock sequence length per command
   always_comb
   begin
      case (cmd_q)
         flash_status_pkg::CMD_PROGRAM: seq_len = 4'd4;
         flash_status_pkg::CMD_SECTOR_ERASE: seq_len = 4'd6;
         flash_status_pkg::CMD_CHIP_ERASE: seq_len = 4'd6;
         flash_status_pkg::CMD_ADD_SECTOR: seq_len = 4'd1;
         default: seq_len = 4'd1;
      endcase
   end

   // command word i of the current sequence
   function automatic logic [35:0] seq_word(input logic [2:0] c, input logic [2:0] i,
      input logic [19:0] a, input logic [15:0] d);
      logic [35:0] w;
      w = {20'h00555, 16'h00AA};
      case (i)
         3'd0: w = {20'h00555, 16'h00AA};
         3'd1: w = {20'h002AA, 16'h0055};
         3'd2: w = (c == flash_status_pkg::CMD_PROGRAM) ? {20'h00555, 16'h00A0} :
            {20'h00555, 16'h0080};
         3'd3: w = (c == flash_status_pkg::CMD_PROGRAM) ? {a, d} : {20'h00555, 16'h00AA};
         3'd4: w = {20'h002AA, 16'h0055};
         default: w = (c == flash_status_pkg::CMD_CHIP_ERASE) ? {20'h00555, 16'h0010} :
            {a, 16'h0030};
      endcase
      if (c == flash_status_pkg::CMD_ADD_SECTOR)
         w = {a, 16'h0030};
      if (c == flash_status_pkg::CMD_SUSPEND)
         w = {a, 16'h00B0};
      if (c == flash_status_pkg::CMD_RESET)
         w = {20'h00000, 16'h00F0};
      return w;
   endfunction

   always_comb
   begin
      logic [35:0] w;
      w = seq_word(cmd_q, idx_q, addr_q, data_q);
      st_d = st_q;
      cmd_d = cmd_q;
      addr_d = addr_q;
      data_d = data_q;
      rdd_d = rdd_q;
      prev_d = prev_q;
      idx_d = idx_q;
      window_open_d = window_open_q;
      erase_run_d = erase_run_q;
      suspended_d = suspended_q;
      failed_d = failed_q;
      refused_d = refused_q;
      req_d = 1'b0;
      op_d = op_q;
      baddr_d = baddr_q;
      bwd_d = bwd_q;
      ev = '0;
      if (wr_acc && paddr == flash_status_pkg::OFS_ADDR)
         addr_d = pwdata[19:0];
      if (wr_acc && paddr == flash_status_pkg::OFS_DATA)
         data_d = pwdata[15:0];
      case (st_q)
         S_IDLE:
         begin
            if (go)
            begin
               cmd_d = pwdata[2:0];
               idx_d = 3'd0;
               refused_d = 1'b0;
               failed_d = 1'b0; // a failure stays visible until the next order
               // only suspend while the internal erase runs
               if (erase_run_q && !window_open_q &&
                  pwdata[2:0] != flash_status_pkg::CMD_SUSPEND)
               begin
                  refused_d = 1'b1;
               end
               else if (pwdata[2:0] == flash_status_pkg::CMD_ADD_SECTOR && !window_open_q)
               begin
                  refused_d = 1'b1;
                  ev[flash_status_pkg::EV_ADD_LATE] = 1'b1;
               end
               else if (pwdata[2:0] == flash_status_pkg::CMD_READ)
                  st_d = S_READ;
               else if (pwdata[2:0] != flash_status_pkg::CMD_NONE)
                  // add sector: window checked before the add as well
                  st_d = (pwdata[2:0] == flash_status_pkg::CMD_ADD_SECTOR) ? S_WIN : S_CMD;
            end
         end
         S_CMD:
         begin
            if (!req_q && !fb.done)
            begin
               req_d = 1'b1;
               op_d = flash_status_pkg::OP_WRITE;
               baddr_d = w[35:16];
               bwd_d = w[15:0];
            end
            if (fb.done)
            begin
               if ({1'b0, idx_q} + 4'd1 >= seq_len)
               begin
                  case (cmd_q)
                     flash_status_pkg::CMD_RESET:
                     begin
                        erase_run_d = 1'b0;
                        window_open_d = 1'b0;
                        suspended_d = 1'b0;
                        st_d = S_DONE;
                     end
                     flash_status_pkg::CMD_SUSPEND:
                     begin
                        suspended_d = 1'b1;
                        st_d = S_POLL1;
                     end
                     default:
                     begin
                        suspended_d = 1'b0;
                        if (cmd_q == flash_status_pkg::CMD_SECTOR_ERASE)
                           window_open_d = 1'b1;
                        st_d = S_POLL1;
                     end
                  endcase
               end
               else
                  idx_d = idx_q + 3'd1;
            end
         end
         S_POLL1, S_POLL2, S_RECHECK, S_WIN, S_WINPOST, S_READ:
         begin
            if (!req_q && !fb.done)
            begin
               req_d = 1'b1;
               op_d = flash_status_pkg::OP_READ;
               baddr_d = addr_q;
            end
            if (fb.done)
            begin
               prev_d = rd;
               rdd_d = rd;
               case (st_q)
                  S_POLL1: st_d = S_POLL2;
                  S_READ: st_d = S_DONE;
                  S_POLL2, S_RECHECK:
                  begin
                     if (!toggled)
                     begin
                        // stopped with polling bit high in suspend is a clean pause
                        if (cmd_q == flash_status_pkg::CMD_SUSPEND &&
                           !rd[flash_status_pkg::POLL_BIT])
                           st_d = S_POLL2;
                        else
                        begin
                           erase_run_d = 1'b0;
                           window_open_d = 1'b0;
                           ev[flash_status_pkg::EV_DONE] = 1'b1;
                           st_d = S_DONE;
                        end
                     end
                     else if (st_q == S_RECHECK)
                     begin
                        failed_d = 1'b1;
                        ev[flash_status_pkg::EV_FAIL] = 1'b1;
                        cmd_d = flash_status_pkg::CMD_RESET;
                        idx_d = 3'd0;
                        st_d = S_CMD;
                     end
                     else if (rd[flash_status_pkg::FAIL_BIT])
                        st_d = S_RECHECK;
                     else if (window_open_q && cmd_q != flash_status_pkg::CMD_CHIP_ERASE)
                        st_d = S_WINPOST;
                     else
                        st_d = S_POLL2;
                  end
                  S_WIN:
                  begin
                     if (rd[flash_status_pkg::WINDOW_BIT])
                     begin
                        window_open_d = 1'b0;
                        erase_run_d = 1'b1;
                        refused_d = 1'b1;
                        ev[flash_status_pkg::EV_ADD_LATE] = 1'b1;
                        st_d = S_POLL2;
                     end
                     else
                        st_d = S_CMD;
                  end
                  default:
                  begin
                     // after a command while the window is open, the window is checked and the job returns if it is still open
                     if (rd[flash_status_pkg::WINDOW_BIT])
                     begin
                        window_open_d = 1'b0;
                        erase_run_d = 1'b1;
                        ev[flash_status_pkg::EV_WINDOW_SHUT] = 1'b1;
                        st_d = S_POLL2;
                     end
                     else
                        st_d = S_DONE; // window open: software may add sectors
                  end
               endcase
            end
         end
         S_DONE:
            st_d = S_IDLE;
         default:
            st_d = S_IDLE;
      endcase
      // sticky status: new events win over the write-one clear
      ist_d = ist_q;
      if (wr_acc && paddr == flash_status_pkg::OFS_IRQ_STAT)
         ist_d = ist_q & ~pwdata[EV_W_L-1:0];
      ist_d = ist_d | ev;
      imask_d = imask_q;
      if (wr_acc && paddr == flash_status_pkg::OFS_IRQ_MASK)
         imask_d = pwdata[EV_W_L-1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= S_IDLE;
         cmd_q <= flash_status_pkg::CMD_NONE;
         addr_q <= 20'h00000;
         data_q <= 16'h0000;
         rdd_q <= 16'h0000;
         prev_q <= 16'h0000;
         idx_q <= 3'd0;
         window_open_q <= 1'b0;
         erase_run_q <= 1'b0;
         suspended_q <= 1'b0;
         failed_q <= 1'b0;
         refused_q <= 1'b0;
         ist_q <= '0;
         imask_q <= '0;
         req_q <= 1'b0;
         op_q <= 2'h0;
         baddr_q <= 20'h00000;
         bwd_q <= 16'h0000;
      end
      else if (clk_en)
      begin
         st_q <= st_d;
         cmd_q <= cmd_d;
         addr_q <= addr_d;
         data_q <= data_d;
         rdd_q <= rdd_d;
         prev_q <= prev_d;
         idx_q <= idx_d;
         window_open_q <= window_open_d;
         erase_run_q <= erase_run_d;
         suspended_q <= suspended_d;
         failed_q <= failed_d;
         refused_q <= refused_d;
         ist_q <= ist_d;
         imask_q <= imask_d;
         req_q <= req_d;
         op_q <= op_d;
         baddr_q <= baddr_d;
         bwd_q <= bwd_d;
      end
   end

   assign irq = |(ist_q & imask_q);
endmodule

//--- testbench/flash_status_props.sv
module flash_status_props
(
   // clocking
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // flash pins
   input wire logic [19:0] fl_addr,
   input wire logic fl_dq_oe_n,
   input wire logic fl_ce_n,
   input wire logic fl_oe_n,
   input wire logic fl_we_n
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   int rd_cnt_q;
   int rd_cnt_d;
   // length of the current read strobe, cleared as soon as it ends
   always_comb
   begin
      rd_cnt_d = fl_oe_n ? 0 : rd_cnt_q + 1;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rd_cnt_q <= 0;
      else
         rd_cnt_q <= rd_cnt_d;
   end
   // a write pulse drives the data bus for its whole length, then the write strobe rises
   sequence s_we_pulse;
      (!fl_we_n && !fl_dq_oe_n && !fl_ce_n)[*8] ##1 fl_we_n;
   endsequence
   a_we_pulse_len: assert property ($fell(fl_we_n) |-> s_we_pulse)
      else $error("write strobe length wrong");
   a_read_len: assert property ($rose(fl_oe_n) |-> rd_cnt_q == flash_status_pkg::READ_ACC_CYC)
      else $error("read strobe length wrong");
   a_read_addr_held: assert property (!fl_oe_n && !$past(fl_oe_n) |-> $stable(fl_addr))
      else $error("address moved during status read");
   a_no_contention: assert property (!fl_oe_n |-> fl_dq_oe_n && fl_we_n)
      else $error("bus driven during read");
   a_strobe_gap: assert property ($rose(fl_we_n) || $rose(fl_oe_n) |-> fl_ce_n)
      else $error("no idle gap after flash cycle");
   a_ce_with_strobe: assert property (!fl_we_n || !fl_oe_n |-> !fl_ce_n)
      else $error("strobe without chip select");
   a_unmapped_err: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
      else $error("unmapped access not flagged");
   a_zero_wait: assert property (psel && penable |-> pready)
      else $error("apb access stalled");
endmodule
bind flash_status_ctrl flash_status_props u_flash_status_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .fl_addr(fl_addr), .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
   .fl_we_n(fl_we_n));

//--- testbench/flash_dev_model.sv
module flash_dev_model
#(
   parameter int WIN_CYC = 10000,
   parameter int ERASE_CYC = 2000,
   parameter int PROG_CYC = 200,
   parameter int LIMIT_CYC = 300
)
(
   // clocking
   input wire logic pclk,
   input wire logic presetn,
   // flash pins
   input wire logic [15:0] fl_dq_out,
   input wire logic fl_ce_n,
   input wire logic fl_oe_n,
   input wire logic fl_we_n,
   output logic [15:0] fl_dq_in,
   output logic ready_busy_out,
   // observation
   output logic [7:0] resets,
   output logic [7:0] restarts,
   output logic erasing
);
   timeunit 1ns;
   timeprecision 1ps;
   typedef enum logic [2:0] {IDLE, PROG, FAIL, WIN, ERASE, SUSP} mode_t;
   mode_t mode;
   logic [15:0] mem, last, pdata, rv;
   logic [7:0] prev, d;
   logic we_d, oe_d, tog, flag;
   int cnt;
   // status byte per mode; unselected bus shows the inverse of the last value
   always_comb
   begin
      d = fl_dq_out[7:0];
      case (mode)
         PROG, FAIL: rv = {8'h00, ~pdata[7], tog, flag, 5'h00};
         WIN: rv = {8'h00, 1'b0, tog, 6'h00}; // window flag low
         ERASE: rv = {8'h00, 1'b0, tog, 2'h0, 1'b1, tog, 2'h0};
         SUSP: rv = {8'h00, 1'b1, 1'b0, 3'h0, tog, 2'h0};
         default: rv = mem;
      endcase
   end
   assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? rv : ~last;
   assign ready_busy_out = !(mode inside {PROG, FAIL, ERASE});
   assign erasing = (mode == ERASE);
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode <= IDLE;
         mem <= 16'hFFFF;
         {last, pdata, prev, we_d, oe_d, tog, flag, cnt, resets, restarts} <= '0;
      end
      else
      begin
         we_d <= fl_we_n;
         oe_d <= fl_oe_n;
         if (!fl_oe_n)
            last <= rv;
         if (fl_oe_n && !oe_d && mode != IDLE)
            tog <= ~tog;
         if (cnt > 0)
            cnt <= cnt - 1;
         if (mode == FAIL && cnt == 1)
            flag <= 1'b1; // pulse limit passed
         if (mode == PROG && cnt == 1)
         begin
            mode <= IDLE;
            mem <= pdata;
         end
         if (mode == WIN && cnt == 1)
         begin
            mode <= ERASE; // time-out over, erase starts
            cnt <= ERASE_CYC;
         end
         if (mode == ERASE && cnt == 1)
            mode <= IDLE;
         // commands take effect when the write strobe rises
         if (fl_we_n && !we_d)
         begin
            prev <= d;
            if (mode == ERASE || mode == SUSP)
            begin
               if (d == 8'hB0)
                  mode <= SUSP; // only suspend is heard
            end
            else if (prev == 8'hA0 && mode == IDLE)
            begin
               pdata <= fl_dq_out;
               mode <= (|(fl_dq_out & ~mem)) ? FAIL : PROG; // 0 to 1 halts
               cnt <= (|(fl_dq_out & ~mem)) ? LIMIT_CYC : PROG_CYC;
            end
            else if (d == 8'hF0)
            begin
               mode <= IDLE;
               flag <= 1'b0;
               resets <= resets + 8'h01;
            end
            else if (d == 8'h30 && (mode == IDLE || mode == WIN))
            begin
               if (mode == WIN)
                  restarts <= restarts + 8'h01;
               mode <= WIN;
               cnt <= WIN_CYC; // full time-out again
            end
            else if (d == 8'h10 && prev == 8'h55 && mode == IDLE)
            begin
               mode <= ERASE; // chip erase has no window
               cnt <= ERASE_CYC;
            end
         end
      end
   end
endmodule

//--- testbench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [7:0] paddr, resets, restarts, r0;
   logic [31:0] pwdata, prdata, rd;
   logic [19:0] fl_addr;
   logic [15:0] fl_dq_out, fl_dq_in;
   logic fl_dq_oe_n, fl_ce_n, fl_oe_n, fl_we_n, ready_busy_out, erasing;
   int mismatches, checks, cyc;
   flash_status_ctrl u_flash_status_ctrl (.*);
   flash_dev_model #(.WIN_CYC(400)) u_flash_dev_model (.*);
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task end_of_test;
      if (mismatches == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // a hang anywhere ends the run as a mismatch
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // one apb transfer; data and error taken at the edge that sees pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task job(input logic [2:0] c, input logic [19:0] a, input logic [15:0] d);
      apb(1'b1, flash_status_pkg::OFS_ADDR, {12'h000, a});
      apb(1'b1, flash_status_pkg::OFS_DATA, {16'h0000, d});
      apb(1'b1, flash_status_pkg::OFS_CTRL, {29'h0000000, c});
      do
         apb(1'b0, flash_status_pkg::OFS_STATUS, 32'h00000000);
      while (rd[0] !== 1'b0);
   endtask
   task s_regs;
      apb(1'b0, flash_status_pkg::OFS_IRQ_MASK, 32'h00000000);
      check("mask reset", rd, 32'h00000000);
      apb(1'b0, flash_status_pkg::OFS_STATUS, 32'h00000000);
      check("status reset", rd, 32'h00000000);
      apb(1'b0, 8'h1C, 32'h00000000);
      check("unmapped err", err, 32'h00000001);
      apb(1'b1, flash_status_pkg::OFS_IRQ_MASK, 32'h0000000F);
   endtask
   task s_program;
      r0 = resets;
      job(flash_status_pkg::CMD_PROGRAM, 20'h00100, 16'h1234);
      apb(1'b0, flash_status_pkg::OFS_IRQ_STAT, 32'h00000000);
      check("prog ok events", rd, 32'h00000001);
      check("irq raised", irq, 32'h00000001);
      apb(1'b1, flash_status_pkg::OFS_IRQ_STAT, 32'h0000000F);
      @(posedge pclk);
      check("irq cleared", irq, 32'h00000000);
      // raising cleared bits must fail and be followed by a reset command
      job(flash_status_pkg::CMD_PROGRAM, 20'h00100, 16'hFFFF);
      apb(1'b0, flash_status_pkg::OFS_STATUS, 32'h00000000);
      check("fail status", rd[2], 1'b1);
      apb(1'b0, flash_status_pkg::OFS_IRQ_STAT, 32'h00000000);
      check("fail event", rd[1], 1'b1);
      check("reset sent", resets, r0 + 8'h01);
      apb(1'b1, flash_status_pkg::OFS_IRQ_STAT, 32'h0000000F);
   endtask
   task s_sector;
      job(flash_status_pkg::CMD_SECTOR_ERASE, 20'h10000, 16'h0000);
      apb(1'b0, flash_status_pkg::OFS_STATUS, 32'h00000000);
      check("window open", rd[3], 1'b1);
      r0 = restarts;
      job(flash_status_pkg::CMD_ADD_SECTOR, 20'h20000, 16'h0000);
      check("add restarts", restarts, r0 + 8'h01);
      apb(1'b0, flash_status_pkg::OFS_STATUS, 32'h00000000);
      check("still open", rd[7:3], 5'b00001);
      repeat (600) @(posedge pclk);
      job(flash_status_pkg::CMD_ADD_SECTOR, 20'h30000, 16'h0000);
      apb(1'b0, flash_status_pkg::OFS_STATUS, 32'h00000000);
      check("late refused", rd[7], 1'b1);
      apb(1'b0, flash_status_pkg::OFS_IRQ_STAT, 32'h00000000);
      check("late event", rd[3], 1'b1);
      check("no restart", restarts, r0 + 8'h01);
      apb(1'b1, flash_status_pkg::OFS_IRQ_STAT, 32'h0000000F);
      @(posedge pclk iff erasing === 1'b0);
   endtask
   task s_chip;
      job(flash_status_pkg::CMD_CHIP_ERASE, 20'h00000, 16'h0000);
      apb(1'b0, flash_status_pkg::OFS_STATUS, 32'h00000000);
      check("chip no window", rd[3:2], 2'b00);
      apb(1'b0, flash_status_pkg::OFS_IRQ_STAT, 32'h00000000);
      check("chip done", rd[0], 1'b1);
   endtask
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, mismatches, checks, cyc} = '0;
      clk_en = 1'b1;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      s_regs();
      s_program();
      s_sector();
      s_chip();
      end_of_test();
   end
endmodule
